// file: epc_defs.svh
// constants for the encoder parameter-channel command interpreter
// What this block does
// - codes 4Ah read data, 4Bh store data, 4Ch field status, 4Dh create field.
// - 4Eh returns free memory; 4Fh replaces the stored access code.
// - 56h serial number and firmware, 57h link setup, 53h encoder reset.
// - guarded commands carry a key byte; host inserts it, device checks it.
// - expected key byte is 55h from reset until changed by command.
// - no fault detected gives status code 00h.
// - init faults: partition table 03h, angular offset 02h, checksum 06h.
// - restart after watchdog supervision reports 07h.
// - internal two-wire bus failure 05h, analog limits missing 04h.
// - received frame parity fault 09h, frame checksum fault 0Ah.
// - wrong data byte count for the command reports 0Ch.
// - argument outside permitted values is rejected with 0Dh.
// - write to protected field 0Eh; resizing a fixed-size field 10h.
// - word address past the end of the field reports 11h.
// - reference to a missing data field reports 12h.
// - speed too high for position 1Fh; unreliable single-turn position 20h.
// - transmitter current critical 1Dh; encoder temperature critical 1Eh.
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
// command codes
`define EPC_C_RD_POS 8'h42
`define EPC_C_SET_POS 8'h43
`define EPC_C_RD_ANA 8'h44
`define EPC_C_RD_CNT 8'h46
`define EPC_C_INC_CNT 8'h47
`define EPC_C_CLR_CNT 8'h49
`define EPC_C_RD_DATA 8'h4A
`define EPC_C_ST_DATA 8'h4B
`define EPC_C_FLD_STAT 8'h4C
`define EPC_C_MK_FLD 8'h4D
`define EPC_C_FREE_MEM 8'h4E
`define EPC_C_CHG_KEY 8'h4F
`define EPC_C_RD_STAT 8'h50
`define EPC_C_RD_TYPE 8'h52
`define EPC_C_RESET 8'h53
`define EPC_C_SET_ADDR 8'h55
`define EPC_C_RD_SER 8'h56
`define EPC_C_CFG_LINK 8'h57
// argument values
`define EPC_ANA_TEMP 8'h48
// reset values
`define EPC_KEY_RST 8'h55
`define EPC_ADDR_RST 8'h40
// status codes
`define EPC_S_OK 8'h00
`define EPC_S_OFFSET 8'h02
`define EPC_S_TABLE 8'h03
`define EPC_S_ALIM 8'h04
`define EPC_S_I2C 8'h05
`define EPC_S_ICSUM 8'h06
`define EPC_S_WDOG 8'h07
`define EPC_S_PARITY 8'h09
`define EPC_S_FCSUM 8'h0A
`define EPC_S_UNKNOWN 8'h0B
`define EPC_S_COUNT 8'h0C
`define EPC_S_ARG 8'h0D
`define EPC_S_WPROT 8'h0E
`define EPC_S_KEY 8'h0F
`define EPC_S_FIXED 8'h10
`define EPC_S_ADDR 8'h11
`define EPC_S_NOFLD 8'h12
`define EPC_S_TXCUR 8'h1D
`define EPC_S_TEMP 8'h1E
`define EPC_S_SPEED 8'h1F
`define EPC_S_STPOS 8'h20
// data byte counts per command, key byte included where guarded
`define EPC_N0 4'h0
`define EPC_N1 4'h1
`define EPC_N2 4'h2
`define EPC_N3 4'h3
`define EPC_N4 4'h4
`define EPC_N5 4'h5
`endif

// file: epc_pkg.sv
// types for the encoder parameter-channel command interpreter
package epc_pkg;
  typedef enum logic [4:0] {
    EPC_OP_NONE, EPC_OP_RD_POS, EPC_OP_SET_POS, EPC_OP_RD_ANA,
    EPC_OP_RD_CNT, EPC_OP_INC_CNT, EPC_OP_CLR_CNT, EPC_OP_RD_DATA,
    EPC_OP_ST_DATA, EPC_OP_FLD_STAT, EPC_OP_MK_FLD, EPC_OP_FREE_MEM,
    EPC_OP_CHG_KEY, EPC_OP_RD_STAT, EPC_OP_RD_TYPE, EPC_OP_RESET,
    EPC_OP_SET_ADDR, EPC_OP_RD_SER, EPC_OP_CFG_LINK
  } epc_op_t;
endpackage : epc_pkg

// file: epc_cmd.sv
// command decoder, key check and status encoder of the parameter channel
`timescale 1ns/1ns
`include "epc_defs.svh"
module epc_cmd #(
  parameter logic [7:0] TYPE_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] SERIAL_ID = 8'hA5 // arbitrary value
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [3:0] cmd_len_in,
  input wire logic [7:0] cmd_key_in,
  input wire logic [7:0] cmd_arg_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic parity_err_in,
  input wire logic csum_err_in,
  input wire logic field_exists_in,
  input wire logic field_wprot_in,
  input wire logic field_fixed_in,
  input wire logic [7:0] field_words_in,
  input wire logic init_table_bad_in,
  input wire logic init_offset_bad_in,
  input wire logic init_csum_bad_in,
  input wire logic wdog_restart_in,
  input wire logic i2c_fail_in,
  input wire logic alim_missing_in,
  input wire logic overspeed_in,
  input wire logic st_unreliable_in,
  input wire logic tx_current_crit_in,
  input wire logic temp_crit_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_status_out,
  output logic [7:0] rsp_data_out,
  output logic op_valid_out,
  output epc_pkg::epc_op_t op_out,
  output logic [7:0] op_arg_out,
  output logic [7:0] bus_addr_out,
  output logic [7:0] access_key_out,
  output logic [7:0] status_out
);
  import epc_pkg::*;

  // command code to operation
  function automatic epc_op_t decode(input logic [7:0] c);
    case (c)
      `EPC_C_RD_POS: decode = EPC_OP_RD_POS;
      `EPC_C_SET_POS: decode = EPC_OP_SET_POS;
      `EPC_C_RD_ANA: decode = EPC_OP_RD_ANA;
      `EPC_C_RD_CNT: decode = EPC_OP_RD_CNT;
      `EPC_C_INC_CNT: decode = EPC_OP_INC_CNT;
      `EPC_C_CLR_CNT: decode = EPC_OP_CLR_CNT;
      `EPC_C_RD_DATA: decode = EPC_OP_RD_DATA;
      `EPC_C_ST_DATA: decode = EPC_OP_ST_DATA;
      `EPC_C_FLD_STAT: decode = EPC_OP_FLD_STAT;
      `EPC_C_MK_FLD: decode = EPC_OP_MK_FLD;
      `EPC_C_FREE_MEM: decode = EPC_OP_FREE_MEM;
      `EPC_C_CHG_KEY: decode = EPC_OP_CHG_KEY;
      `EPC_C_RD_STAT: decode = EPC_OP_RD_STAT;
      `EPC_C_RD_TYPE: decode = EPC_OP_RD_TYPE;
      `EPC_C_RESET: decode = EPC_OP_RESET;
      `EPC_C_SET_ADDR: decode = EPC_OP_SET_ADDR;
      `EPC_C_RD_SER: decode = EPC_OP_RD_SER;
      `EPC_C_CFG_LINK: decode = EPC_OP_CFG_LINK;
      default: decode = EPC_OP_NONE;
    endcase
  endfunction : decode

  // data bytes each operation must carry
  function automatic logic [3:0] want_len(input epc_op_t o);
    case (o)
      EPC_OP_SET_POS: want_len = `EPC_N5;
      EPC_OP_RD_ANA, EPC_OP_INC_CNT, EPC_OP_CLR_CNT: want_len = `EPC_N1;
      EPC_OP_FLD_STAT, EPC_OP_RESET: want_len = `EPC_N1;
      EPC_OP_RD_DATA, EPC_OP_CHG_KEY: want_len = `EPC_N2;
      EPC_OP_SET_ADDR, EPC_OP_CFG_LINK: want_len = `EPC_N2;
      EPC_OP_MK_FLD: want_len = `EPC_N3;
      EPC_OP_ST_DATA: want_len = `EPC_N4;
      default: want_len = `EPC_N0;
    endcase
  endfunction : want_len

  // operations that carry the protection key byte
  function automatic logic guarded(input epc_op_t o);
    case (o)
      EPC_OP_SET_POS, EPC_OP_INC_CNT, EPC_OP_CLR_CNT: guarded = 1'b1;
      EPC_OP_ST_DATA, EPC_OP_MK_FLD, EPC_OP_CHG_KEY: guarded = 1'b1;
      EPC_OP_RESET, EPC_OP_SET_ADDR, EPC_OP_CFG_LINK: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  logic [7:0] key_q;
  logic [7:0] addr_q;
  logic [7:0] status_q;
  epc_op_t cmd_op;
  logic [7:0] cmd_err;
  logic [7:0] env_code;
  logic env_fault;
  logic cmd_ok;

  // command checks in priority order, frame faults first
  always_comb begin
    cmd_op = decode(cmd_code_in);
    cmd_err = `EPC_S_OK;
    if (parity_err_in) begin
      cmd_err = `EPC_S_PARITY;
    end else if (csum_err_in) begin
      cmd_err = `EPC_S_FCSUM;
    end else if (cmd_op == EPC_OP_NONE) begin
      cmd_err = `EPC_S_UNKNOWN;
    end else if (cmd_len_in != want_len(cmd_op)) begin
      cmd_err = `EPC_S_COUNT;
    end else if (guarded(cmd_op) && cmd_key_in != key_q) begin
      cmd_err = `EPC_S_KEY;
    end else if (cmd_op == EPC_OP_RD_ANA && cmd_arg_in != `EPC_ANA_TEMP) begin
      cmd_err = `EPC_S_ARG;
    end else if ((cmd_op == EPC_OP_RD_DATA || cmd_op == EPC_OP_ST_DATA ||
                  cmd_op == EPC_OP_FLD_STAT || cmd_op == EPC_OP_MK_FLD) &&
                 !field_exists_in) begin
      cmd_err = `EPC_S_NOFLD;
    end else if (cmd_op == EPC_OP_ST_DATA && field_wprot_in) begin
      cmd_err = `EPC_S_WPROT;
    end else if (cmd_op == EPC_OP_MK_FLD && field_fixed_in) begin
      cmd_err = `EPC_S_FIXED;
    end else if ((cmd_op == EPC_OP_RD_DATA || cmd_op == EPC_OP_ST_DATA) &&
                 cmd_addr_in >= field_words_in) begin
      cmd_err = `EPC_S_ADDR;
    end
  end

  assign cmd_ok = cmd_valid_in && (cmd_err == `EPC_S_OK);

  // monitored faults, initialisation faults first
  always_comb begin
    env_fault = 1'b1;
    if (init_table_bad_in) begin
      env_code = `EPC_S_TABLE;
    end else if (init_offset_bad_in) begin
      env_code = `EPC_S_OFFSET;
    end else if (init_csum_bad_in) begin
      env_code = `EPC_S_ICSUM;
    end else if (wdog_restart_in) begin
      env_code = `EPC_S_WDOG;
    end else if (i2c_fail_in) begin
      env_code = `EPC_S_I2C;
    end else if (alim_missing_in) begin
      env_code = `EPC_S_ALIM;
    end else if (overspeed_in) begin
      env_code = `EPC_S_SPEED;
    end else if (st_unreliable_in) begin
      env_code = `EPC_S_STPOS;
    end else if (tx_current_crit_in) begin
      env_code = `EPC_S_TXCUR;
    end else if (temp_crit_in) begin
      env_code = `EPC_S_TEMP;
    end else begin
      env_code = `EPC_S_OK;
      env_fault = 1'b0;
    end
  end

  // protection key, replaced only by an accepted change command
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      key_q <= `EPC_KEY_RST;
    end else if (cmd_ok && cmd_op == EPC_OP_CHG_KEY) begin
      key_q <= cmd_arg_in;
    end
  end

  // bus address, reassigned only by an accepted address command
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= `EPC_ADDR_RST;
    end else if (cmd_ok && cmd_op == EPC_OP_SET_ADDR) begin
      addr_q <= cmd_arg_in;
    end
  end

  // sticky status: faults set it, a status read clears it, set wins
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_q <= `EPC_S_OK;
    end else if (cmd_valid_in && !cmd_ok) begin
      status_q <= cmd_err;
    end else if (env_fault) begin
      status_q <= env_code;
    end else if (cmd_ok && cmd_op == EPC_OP_RD_STAT) begin
      status_q <= `EPC_S_OK;
    end
  end

  // one answer per command, one cycle after it is presented
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_status_out <= `EPC_S_OK;
      rsp_data_out <= 8'h00;
    end else begin
      rsp_valid_out <= cmd_valid_in;
      if (cmd_valid_in) begin
        rsp_status_out <= cmd_ok ? status_q : cmd_err;
        case (cmd_ok ? cmd_op : EPC_OP_NONE)
          EPC_OP_RD_STAT: rsp_data_out <= status_q;
          EPC_OP_RD_TYPE: rsp_data_out <= TYPE_ID;
          EPC_OP_SET_ADDR: rsp_data_out <= cmd_arg_in;
          EPC_OP_RD_SER: rsp_data_out <= SERIAL_ID;
          default: rsp_data_out <= 8'h00;
        endcase
      end
    end
  end

  // action strobe to the datapath, only for accepted commands
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_valid_out <= 1'b0;
      op_out <= EPC_OP_NONE;
      op_arg_out <= 8'h00;
    end else begin
      op_valid_out <= cmd_ok;
      op_out <= cmd_ok ? cmd_op : EPC_OP_NONE;
      if (cmd_ok) begin
        op_arg_out <= cmd_arg_in;
      end
    end
  end

  assign bus_addr_out = addr_q;
  assign access_key_out = key_q;
  assign status_out = status_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  unknown_code_a: assert property (
    cmd_valid_in && decode(cmd_code_in) == EPC_OP_NONE && !parity_err_in && !csum_err_in
    |=> rsp_valid_out && rsp_status_out == `EPC_S_UNKNOWN && !op_valid_out)
    else $error("unknown code not rejected");
  parity_fault_a: assert property (
    cmd_valid_in && parity_err_in
    |=> rsp_status_out == `EPC_S_PARITY && !op_valid_out && status_q == `EPC_S_PARITY)
    else $error("parity fault not reported");
  key_reject_a: assert property (
    cmd_valid_in && !parity_err_in && !csum_err_in && guarded(decode(cmd_code_in))
    && cmd_len_in == want_len(decode(cmd_code_in)) && cmd_key_in != key_q
    |=> !op_valid_out && rsp_status_out == `EPC_S_KEY)
    else $error("bad key accepted");
  key_stable_a: assert property (
    !(cmd_ok && cmd_op == EPC_OP_CHG_KEY) |=> $stable(key_q))
    else $error("key changed without command");
  count_check_a: assert property (
    cmd_valid_in && !parity_err_in && !csum_err_in && cmd_op != EPC_OP_NONE
    && cmd_len_in != want_len(cmd_op) |=> rsp_status_out == `EPC_S_COUNT)
    else $error("count fault not reported");
  addr_range_a: assert property (
    cmd_ok && cmd_op == EPC_OP_RD_DATA |-> cmd_addr_in < field_words_in)
    else $error("read past field end accepted");
  type_read_a: assert property (
    cmd_ok && cmd_op == EPC_OP_RD_TYPE |=> rsp_data_out == TYPE_ID && op_out == EPC_OP_RD_TYPE)
    else $error("type answer wrong");
  temp_status_a: assert property (
    !cmd_valid_in && temp_crit_in && env_code == `EPC_S_TEMP |=> status_q == `EPC_S_TEMP)
    else $error("temperature fault not latched");
  init_table_a: assert property (
    !cmd_valid_in && init_table_bad_in |=> status_q == `EPC_S_TABLE)
    else $error("table fault not latched");
  clean_status_a: assert property (
    !env_fault && !cmd_valid_in && status_q == `EPC_S_OK |=> status_q == `EPC_S_OK)
    else $error("status set without fault");
  write_prot_a: assert property (
    cmd_ok && cmd_op == EPC_OP_ST_DATA |-> !field_wprot_in && field_exists_in)
    else $error("protected write accepted");

  // argument, frame checksum, field, monitored fault, address and status-clear checks
  arg_range_a: assert property (
    cmd_valid_in && !parity_err_in && !csum_err_in && cmd_op == EPC_OP_RD_ANA
    && cmd_len_in == want_len(cmd_op) && cmd_arg_in != `EPC_ANA_TEMP
    |=> rsp_status_out == `EPC_S_ARG && !op_valid_out)
    else $error("bad analog channel accepted");
  csum_fault_a: assert property (
    cmd_valid_in && !parity_err_in && csum_err_in
    |=> rsp_status_out == `EPC_S_FCSUM && !op_valid_out && status_q == `EPC_S_FCSUM)
    else $error("checksum fault not reported");
  field_exists_a: assert property (
    cmd_ok && (cmd_op == EPC_OP_FLD_STAT || cmd_op == EPC_OP_ST_DATA) |-> field_exists_in)
    else $error("missing field accepted");
  fixed_size_a: assert property (
    cmd_ok && cmd_op == EPC_OP_MK_FLD |-> !field_fixed_in)
    else $error("fixed field resized");
  wdog_status_a: assert property (
    !cmd_valid_in && wdog_restart_in && !init_table_bad_in && !init_offset_bad_in
    && !init_csum_bad_in |=> status_q == `EPC_S_WDOG)
    else $error("watchdog restart not latched");
  bus_fail_a: assert property (
    !cmd_valid_in && i2c_fail_in && !init_table_bad_in && !init_offset_bad_in
    && !init_csum_bad_in && !wdog_restart_in |=> status_q == `EPC_S_I2C)
    else $error("peripheral bus fault not latched");
  speed_status_a: assert property (
    !cmd_valid_in && overspeed_in && !init_table_bad_in && !init_offset_bad_in
    && !init_csum_bad_in && !wdog_restart_in && !i2c_fail_in && !alim_missing_in
    |=> status_q == `EPC_S_SPEED)
    else $error("overspeed not latched");
  addr_stable_a: assert property (
    !(cmd_ok && cmd_op == EPC_OP_SET_ADDR) |=> $stable(addr_q))
    else $error("address changed without command");
  status_clear_a: assert property (
    cmd_ok && cmd_op == EPC_OP_RD_STAT && !env_fault
    |=> status_q == `EPC_S_OK && rsp_data_out == $past(status_q))
    else $error("status read did not clear");

  accept_c: cover property (cmd_ok ##1 op_valid_out);
  chg_key_c: cover property (cmd_ok && cmd_op == EPC_OP_CHG_KEY);
  status_rd_c: cover property (env_fault ##1 cmd_ok && cmd_op == EPC_OP_RD_STAT);
  reject_c: cover property (cmd_valid_in && cmd_err == `EPC_S_NOFLD);
endmodule : epc_cmd

// file: epc_host.sv
// host model that hands assembled command frames to the interpreter
`timescale 1ns/1ns
module epc_host (
  input wire logic clk_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out,
  output logic [3:0] cmd_len_out,
  output logic [7:0] cmd_key_out,
  output logic [7:0] cmd_arg_out,
  output logic [7:0] cmd_addr_out
);
  // quiet frame lines at time zero
  initial begin
    cmd_valid_out = 1'b0;
    {cmd_code_out, cmd_len_out, cmd_key_out, cmd_arg_out, cmd_addr_out} = '0;
  end
  // one frame for one cycle, then the stale fields are scrambled
  task automatic send(input logic [7:0] code, input logic [3:0] len, input logic [7:0] key,
      input logic [7:0] arg, input logic [7:0] addr);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= code;
    cmd_len_out <= len;
    cmd_key_out <= key;
    cmd_arg_out <= arg;
    cmd_addr_out <= addr;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    {cmd_code_out, cmd_len_out, cmd_key_out, cmd_arg_out, cmd_addr_out} <=
      ~{code, len, key, arg, addr};
  endtask : send
endmodule : epc_host

// file: tb_encoder_param_channel_cmds.sv
// self-checking bench for the parameter-channel command interpreter
`timescale 1ns/1ns
module tb_encoder_param_channel_cmds;
  import epc_pkg::*;
  localparam logic [7:0] TYPE_V = 8'h5A; // arbitrary value
  localparam logic [7:0] SER_V = 8'hA5; // arbitrary value
  localparam logic [7:0] CODES [18] = '{8'h42, 8'h43, 8'h44, 8'h46, 8'h47, 8'h49, 8'h4A,
    8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h52, 8'h53, 8'h55, 8'h56, 8'h57};
  localparam logic [3:0] LENS [18] = '{4'h0, 4'h5, 4'h1, 4'h0, 4'h1, 4'h1, 4'h2, 4'h4,
    4'h1, 4'h3, 4'h0, 4'h2, 4'h0, 4'h0, 4'h1, 4'h2, 4'h0, 4'h2};
  localparam logic [7:0] MON [10] = '{8'h03, 8'h02, 8'h06, 8'h07, 8'h05, 8'h04, 8'h1F,
    8'h20, 8'h1D, 8'h1E};
  logic clk_in;
  logic resetn_q = 1'b0;
  logic [1:0] err_q = 2'b00;
  logic [2:0] fld_q = 3'b100;
  logic [7:0] words_q = 8'h10;
  logic [9:0] flt_q = 10'h000;
  logic [7:0] key_e = 8'h55;
  logic [7:0] addr_e = 8'h40;
  logic [7:0] st_e = 8'h00;
  int miscompares = 0;
  int check_count = 0;
  logic cv;
  logic [7:0] cc, ck, ca, cd, rsp_status, rsp_data, op_arg, bus_addr, access_key, status;
  logic [3:0] cl;
  logic rsp_valid, op_valid;
  epc_op_t op;
  // far side and block under test
  epc_host epc_host_i (.clk_in(clk_in), .cmd_valid_out(cv), .cmd_code_out(cc),
    .cmd_len_out(cl), .cmd_key_out(ck), .cmd_arg_out(ca), .cmd_addr_out(cd));
  epc_cmd #(.TYPE_ID(TYPE_V), .SERIAL_ID(SER_V)) epc_cmd_i (.clk_in(clk_in),
    .resetn_in(resetn_q), .cmd_valid_in(cv), .cmd_code_in(cc), .cmd_len_in(cl),
    .cmd_key_in(ck), .cmd_arg_in(ca), .cmd_addr_in(cd), .parity_err_in(err_q[1]),
    .csum_err_in(err_q[0]), .field_exists_in(fld_q[2]), .field_wprot_in(fld_q[1]),
    .field_fixed_in(fld_q[0]), .field_words_in(words_q), .init_table_bad_in(flt_q[0]),
    .init_offset_bad_in(flt_q[1]), .init_csum_bad_in(flt_q[2]), .wdog_restart_in(flt_q[3]),
    .i2c_fail_in(flt_q[4]), .alim_missing_in(flt_q[5]), .overspeed_in(flt_q[6]),
    .st_unreliable_in(flt_q[7]), .tx_current_crit_in(flt_q[8]), .temp_crit_in(flt_q[9]),
    .rsp_valid_out(rsp_valid), .rsp_status_out(rsp_status), .rsp_data_out(rsp_data),
    .op_valid_out(op_valid), .op_out(op), .op_arg_out(op_arg), .bus_addr_out(bus_addr),
    .access_key_out(access_key), .status_out(status));
  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // single comparison point
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one frame with expected status ec, 00 meaning accepted
  task automatic xact(input logic [7:0] c, input logic [3:0] n, input logic [7:0] a,
      input logic [7:0] ad, input logic [1:0] e, input logic [2:0] f, input logic [7:0] ec);
    logic ok;
    logic [7:0] d_e;
    ok = (ec === 8'h00);
    d_e = (c == 8'h50) ? st_e : (c == 8'h52) ? TYPE_V : (c == 8'h56) ? SER_V :
      (c == 8'h55) ? a : 8'h00;
    @(posedge clk_in);
    err_q <= e;
    fld_q <= f;
    host_send(c, n, (ec == 8'h0F) ? ~key_e : key_e, a, ad);
    #1;
    chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    chk("rsp_status", rsp_status, ok ? st_e : ec);
    chk("op_valid", {7'h00, op_valid}, {7'h00, ok});
    if (ok) begin
      chk("rsp_data", rsp_data, d_e);
      chk("op_arg", op_arg, a);
      if (c == 8'h4F) key_e = a;
      if (c == 8'h55) addr_e = a;
      if (c == 8'h50) st_e = 8'h00;
    end else begin
      chk("op", {3'h0, op}, {3'h0, EPC_OP_NONE});
      st_e = ec;
    end
    chk("access_key", access_key, key_e);
    chk("bus_addr", bus_addr, addr_e);
    chk("status", status, st_e);
  endtask : xact
  // wrapper so the key byte comes from the host model
  task automatic host_send(input logic [7:0] c, input logic [3:0] n, input logic [7:0] k,
      input logic [7:0] a, input logic [7:0] ad);
    epc_host_i.send(c, n, k, a, ad);
  endtask : host_send
  // values just after reset
  task automatic t_reset();
    #1;
    chk("bus_addr", bus_addr, 8'h40);
    chk("access_key", access_key, 8'h55);
    chk("status", status, 8'h00);
    chk("op_valid", {7'h00, op_valid}, 8'h00);
  endtask : t_reset
  // every command code in turn, two idle cycles between frames
  task automatic t_codes();
    epc_op_t op_e;
    op_e = EPC_OP_RD_POS;
    for (int i = 0; i < 18; i++) begin
      xact(CODES[i], LENS[i], 8'h48, 8'h00, 2'b00, 3'b100, 8'h00);
      chk("op", {3'h0, op}, {3'h0, op_e});
      op_e = op_e.next();
    end
  endtask : t_codes
  // every refusal code, then a clean boundary access and a status read
  task automatic t_errors();
    xact(8'h42, 4'h0, 8'h00, 8'h00, 2'b11, 3'b100, 8'h09);
    xact(8'h42, 4'h0, 8'h00, 8'h00, 2'b01, 3'b100, 8'h0A);
    xact(8'h45, 4'h0, 8'h00, 8'h00, 2'b00, 3'b100, 8'h0B);
    xact(8'h42, 4'h1, 8'h00, 8'h00, 2'b00, 3'b100, 8'h0C);
    xact(8'h4F, 4'h2, 8'h99, 8'h00, 2'b00, 3'b100, 8'h0F);
    xact(8'h44, 4'h1, 8'h47, 8'h00, 2'b00, 3'b100, 8'h0D);
    xact(8'h4A, 4'h2, 8'h00, 8'h00, 2'b00, 3'b000, 8'h12);
    xact(8'h4B, 4'h4, 8'h00, 8'h00, 2'b00, 3'b110, 8'h0E);
    xact(8'h4D, 4'h3, 8'h00, 8'h00, 2'b00, 3'b101, 8'h10);
    xact(8'h4A, 4'h2, 8'h00, 8'h10, 2'b00, 3'b100, 8'h11);
    xact(8'h4B, 4'h4, 8'h00, 8'h0F, 2'b00, 3'b100, 8'h00);
    xact(8'h50, 4'h0, 8'h00, 8'h00, 2'b00, 3'b100, 8'h00);
  endtask : t_errors
  // monitored faults in priority order, then a clearing status read
  task automatic t_monitor();
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      flt_q <= 10'h3FF << i;
      repeat (2) @(posedge clk_in);
      #1;
      chk("status", status, MON[i]);
    end
    @(posedge clk_in);
    flt_q <= 10'h000;
    st_e = MON[9];
    xact(8'h50, 4'h0, 8'h00, 8'h00, 2'b00, 3'b100, 8'h00);
  endtask : t_monitor
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_q <= 1'b1;
    t_reset();
    t_codes();
    t_errors();
    t_monitor();
    complete_run();
  end
  // watchdog, far beyond the roughly 150 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end
endmodule : tb_encoder_param_channel_cmds
